// File: rtl/pci_bridge_txn_control.sv
/*
  Transaction controller of a hub-to-PCI bridge: hub-side master engine with
  configuration translation and lock, PCI-side target decisions with a
  delayed-read queue, and a small register port.
  Assumes every input is synchronous to ref_clk_i; the PCI pads and the hub
  packet layer sit outside and present one-cycle request pulses.
*/
// The plain strobed port and the register addresses were left to the implementer.
`include "pci_bridge_txn_control_defs.svh"

module pci_bridge_txn_control (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Hub-originated requests
  input wire logic hub_req_i,
  input wire logic [3:0] hub_cmd_i,
  input wire logic [31:0] hub_addr_i,
  input wire logic [3:0] hub_be_i,
  input wire logic [7:0] hub_len_i,
  input wire logic hub_locked_i,
  input wire logic hub_unlock_i,
  input wire logic [31:0] hub_wdata_i,
  output logic hub_ready_o,
  output logic hub_cpl_o,
  output logic [1:0] hub_cpl_status_o,
  output logic hub_cpl_disc_o,
  output logic own_cfg_o,
  output logic [31:0] hub_rdata_o,
  // Secondary bus as master
  input wire logic sec_gnt_n_i,
  input wire logic target_claim_n_i,
  input wire logic target_ready_n_i,
  input wire logic target_stop_n_i,
  input wire logic [31:0] sec_addr_data_i,
  output logic [31:0] sec_addr_data_o,
  output logic sec_addr_data_oe_o,
  output logic [3:0] sec_cmd_o,
  output logic cycle_frame_n_o,
  output logic sec_bus_lock_n_o,
  // Secondary bus as target
  input wire logic pci_req_i,
  input wire logic [3:0] pci_cmd_i,
  input wire logic [31:0] pci_addr_i,
  input wire logic pci_par_i,
  input wire logic pci_in_window_i,
  input wire logic post_full_i,
  input wire logic peer_locked_i,
  output logic [2:0] tgt_resp_o,
  output logic upstream_block_o,
  // Delayed-read queue towards the hub
  input wire logic hub_rd_done_i,
  input wire logic [1:0] hub_rd_tag_i,
  input wire logic hub_rd_abort_i,
  output logic dtq_issue_o,
  output logic [1:0] dtq_tag_o,
  output logic [31:0] dtq_addr_o,
  output logic [3:0] dtq_cmd_o,
  output logic dtq_par_o,
  output logic dtq_prefetch_o,
  output logic [10:0] dtq_len_o
);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [31:0] ctrl, next_ctrl;
  logic rma, next_rma;
  logic [31:0] next_rdata;
  logic lock_active, dtq_full;
  logic rma_set;
  wire [7:0] sec_bus = ctrl[`CTRL_SEC_LSB +: 8];
  wire [7:0] sub_bus = ctrl[`CTRL_SUB_LSB +: 8];
  wire pf_dis = ctrl[`CTRL_PFDIS_BIT];

  // Received-abort flag: hardware set wins over a write-one clear
  always_comb begin
    next_ctrl = ctrl;
    next_rma = rma;
    next_rdata = 32'h0000_0000;
    if (reg_wr_i && reg_addr_i == `REG_CTRL) begin
      next_ctrl = reg_wdata_i & 32'h0001_FFFF;
    end
    if (reg_wr_i && reg_addr_i == `REG_STATUS && reg_wdata_i[`STATUS_RMA_BIT]) begin
      next_rma = 1'b0;
    end
    if (rma_set) begin
      next_rma = 1'b1;
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        `REG_CTRL: next_rdata = ctrl;
        `REG_STATUS: next_rdata = {29'h0, dtq_full, lock_active, rma};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ctrl <= `CTRL_RESET;
      rma <= 1'b0;
      reg_rdata_o <= 32'h0000_0000;
    end else begin
      ctrl <= next_ctrl;
      rma <= next_rma;
      reg_rdata_o <= next_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // Hub-side master engine
  // ----------------------------------------------------------------------
  pci_bridge_txn_pkg::master_state_e mst, next_mst;
  logic [31:0] m_addr, next_m_addr;
  logic [3:0] m_cmd, next_m_cmd;
  logic [3:0] m_be, next_m_be;
  logic [7:0] m_len, next_m_len;
  logic m_locked, next_m_locked;
  logic m_special, next_m_special;
  logic m_disc, next_m_disc;
  logic [2:0] wait_cnt, next_wait_cnt;
  logic [7:0] lat_cnt, next_lat_cnt;
  logic next_lock;
  logic next_cpl, next_cpl_disc, next_own;
  logic [1:0] next_status;
  logic [31:0] next_hub_rdata;
  logic [31:0] t0_addr;
  logic is_cfg, hub_is_wr;
  wire [4:0] h_dev = hub_addr_i[15:11];
  wire [7:0] h_bus = hub_addr_i[23:16];

  // One-hot device select for the converted address; numbers 16 and up fall off
  always_comb begin
    t0_addr = {16'h0000, 5'h00, hub_addr_i[10:2], 2'b00};
    if (h_dev < 5'h10) begin
      t0_addr[5'h10 + h_dev] = 1'b1;
    end
  end

  assign is_cfg = hub_cmd_i == pci_bridge_txn_pkg::CMD_CFG_RD
    || hub_cmd_i == pci_bridge_txn_pkg::CMD_CFG_WR;
  assign hub_is_wr = hub_cmd_i[0];
  assign hub_ready_o = mst == pci_bridge_txn_pkg::M_IDLE;

  // Decode on acceptance, then frame, claim wait, data phases, completion
  always_comb begin
    next_mst = mst;
    next_m_addr = m_addr;
    next_m_cmd = m_cmd;
    next_m_be = m_be;
    next_m_len = m_len;
    next_m_locked = m_locked;
    next_m_special = m_special;
    next_m_disc = m_disc;
    next_wait_cnt = wait_cnt;
    next_lat_cnt = lat_cnt;
    next_lock = lock_active;
    next_cpl = 1'b0;
    next_cpl_disc = 1'b0;
    next_own = 1'b0;
    next_status = hub_cpl_status_o;
    next_hub_rdata = hub_rdata_o;
    rma_set = 1'b0;
    case (mst)
      pci_bridge_txn_pkg::M_IDLE: begin
        if (hub_req_i) begin
          next_m_addr = hub_addr_i;
          next_m_cmd = hub_cmd_i;
          next_m_be = hub_be_i;
          next_m_len = (hub_len_i == 8'h00) ? 8'h01 : hub_len_i;
          next_m_locked = hub_locked_i;
          next_m_special = 1'b0;
          next_m_disc = 1'b0;
          next_mst = pci_bridge_txn_pkg::M_ARB;
          if (is_cfg && hub_addr_i[1:0] == 2'b00) begin
            next_mst = pci_bridge_txn_pkg::M_IDLE;
            next_cpl = 1'b1;
            next_own = h_dev >= `OWN_DEV_MIN;
            next_status = next_own ? pci_bridge_txn_pkg::CPL_NORMAL
                                   : pci_bridge_txn_pkg::CPL_MABORT;
          end else if (is_cfg && hub_addr_i[1:0] == 2'b01) begin
            if (h_bus == sec_bus && hub_is_wr && h_dev == `SPC_DEV
                && hub_addr_i[10:8] == `SPC_FUNC && hub_addr_i[7:2] == `SPC_REG) begin
              next_m_cmd = pci_bridge_txn_pkg::CMD_SPECIAL;
              next_m_special = 1'b1;
              next_m_len = 8'h01;
              next_m_disc = hub_len_i > 8'h01;
            end else if (h_bus == sec_bus) begin
              next_m_addr = t0_addr;
            end else if (!(h_bus > sec_bus && h_bus <= sub_bus)) begin
              next_mst = pci_bridge_txn_pkg::M_IDLE;
              next_cpl = 1'b1;
              next_status = pci_bridge_txn_pkg::CPL_MABORT;
            end
          end else if (is_cfg) begin
            next_mst = pci_bridge_txn_pkg::M_IDLE;
            next_cpl = 1'b1;
            next_status = pci_bridge_txn_pkg::CPL_MABORT;
          end
        end
      end
      pci_bridge_txn_pkg::M_ARB: begin
        if (!sec_gnt_n_i) begin
          next_mst = pci_bridge_txn_pkg::M_ADDR;
        end
      end
      pci_bridge_txn_pkg::M_ADDR: begin
        next_wait_cnt = 3'h1;
        next_lat_cnt = 8'h00;
        next_mst = pci_bridge_txn_pkg::M_WAIT;
      end
      pci_bridge_txn_pkg::M_WAIT: begin
        next_wait_cnt = wait_cnt + 3'h1;
        if (!target_claim_n_i && !m_special) begin
          next_mst = pci_bridge_txn_pkg::M_DATA;
        end else if (wait_cnt == `CLAIM_WAIT_CYC) begin
          next_mst = pci_bridge_txn_pkg::M_IDLE;
          next_cpl = 1'b1;
          next_cpl_disc = m_disc;
          // Special cycles expect nobody to claim them
          next_status = m_special ? pci_bridge_txn_pkg::CPL_NORMAL
                                  : pci_bridge_txn_pkg::CPL_MABORT;
          rma_set = !m_special;
        end
      end
      pci_bridge_txn_pkg::M_DATA: begin
        next_lat_cnt = (lat_cnt == `LAT_TIMER_CYC) ? lat_cnt : lat_cnt + 8'h01;
        if (!target_ready_n_i && !target_claim_n_i) begin
          next_m_len = m_len - 8'h01;
          next_m_addr = m_addr + 32'h0000_0004;
          next_hub_rdata = sec_addr_data_i;
          if (m_locked && m_cmd == pci_bridge_txn_pkg::CMD_MEM_RD && m_be != 4'h0) begin
            next_lock = 1'b1;
          end
        end
        if (!target_stop_n_i && target_claim_n_i) begin
          next_mst = pci_bridge_txn_pkg::M_IDLE;
          next_cpl = 1'b1;
          next_status = pci_bridge_txn_pkg::CPL_TABORT;
        end else if (next_m_len == 8'h00) begin
          next_mst = pci_bridge_txn_pkg::M_IDLE;
          next_cpl = 1'b1;
          next_status = pci_bridge_txn_pkg::CPL_NORMAL;
        end else if (!target_stop_n_i
                     || (lat_cnt == `LAT_TIMER_CYC && sec_gnt_n_i)) begin
          next_mst = pci_bridge_txn_pkg::M_ARB;
        end
      end
      default: next_mst = pci_bridge_txn_pkg::M_IDLE;
    endcase
    if (hub_unlock_i) begin
      next_lock = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mst <= pci_bridge_txn_pkg::M_IDLE;
      m_addr <= 32'h0000_0000;
      m_cmd <= 4'h0;
      m_be <= 4'h0;
      m_len <= 8'h00;
      m_locked <= 1'b0;
      m_special <= 1'b0;
      m_disc <= 1'b0;
      wait_cnt <= 3'h0;
      lat_cnt <= 8'h00;
      lock_active <= 1'b0;
      hub_cpl_o <= 1'b0;
      hub_cpl_disc_o <= 1'b0;
      own_cfg_o <= 1'b0;
      hub_cpl_status_o <= 2'h0;
      hub_rdata_o <= 32'h0000_0000;
    end else begin
      mst <= next_mst;
      m_addr <= next_m_addr;
      m_cmd <= next_m_cmd;
      m_be <= next_m_be;
      m_len <= next_m_len;
      m_locked <= next_m_locked;
      m_special <= next_m_special;
      m_disc <= next_m_disc;
      wait_cnt <= next_wait_cnt;
      lat_cnt <= next_lat_cnt;
      lock_active <= next_lock;
      hub_cpl_o <= next_cpl;
      hub_cpl_disc_o <= next_cpl_disc;
      own_cfg_o <= next_own;
      hub_cpl_status_o <= next_status;
      hub_rdata_o <= next_hub_rdata;
    end
  end

  // Bus drive follows the state; address in the address phase, write data after
  wire m_active = mst == pci_bridge_txn_pkg::M_ADDR || mst == pci_bridge_txn_pkg::M_WAIT
    || mst == pci_bridge_txn_pkg::M_DATA;
  assign cycle_frame_n_o = !m_active;
  assign sec_bus_lock_n_o = !(m_active && (lock_active || m_locked));
  assign sec_cmd_o = m_cmd;
  assign sec_addr_data_oe_o = mst == pci_bridge_txn_pkg::M_ADDR || (m_active && m_cmd[0]);
  assign sec_addr_data_o = (mst == pci_bridge_txn_pkg::M_ADDR) ? m_addr : hub_wdata_i;

  // ----------------------------------------------------------------------
  // PCI-side target and delayed-read queue
  // ----------------------------------------------------------------------
  logic [`DTQ_DEPTH-1:0] q_valid, next_q_valid, q_done, next_q_done, q_abort, next_q_abort;
  logic [31:0] q_addr [`DTQ_DEPTH];
  logic [31:0] next_q_addr [`DTQ_DEPTH];
  logic [3:0] q_cmd [`DTQ_DEPTH];
  logic [3:0] next_q_cmd [`DTQ_DEPTH];
  logic [`DTQ_DEPTH-1:0] q_hit;
  logic [1:0] hit_idx, free_idx;
  logic [2:0] next_resp;
  logic next_issue, next_pf;
  logic [10:0] next_len;
  wire mem_rd = pci_cmd_i == pci_bridge_txn_pkg::CMD_MEM_RD
    || pci_cmd_i == pci_bridge_txn_pkg::CMD_MEM_RDM || pci_cmd_i == pci_bridge_txn_pkg::CMD_MEM_RDL;
  wire mem_wr = pci_cmd_i == pci_bridge_txn_pkg::CMD_MEM_WR
    || pci_cmd_i == pci_bridge_txn_pkg::CMD_MEM_WRI;

  // Address and command comparison per queue entry
  genvar gi;
  generate
    for (gi = 0; gi < `DTQ_DEPTH; gi++) begin : g_hit
      assign q_hit[gi] = q_valid[gi] && q_addr[gi] == pci_addr_i && q_cmd[gi] == pci_cmd_i;
    end
  endgenerate

  assign dtq_full = &q_valid;
  assign upstream_block_o = lock_active;

  always_comb begin
    hit_idx = 2'h0;
    free_idx = 2'h0;
    for (int i = `DTQ_DEPTH - 1; i >= 0; i--) begin
      if (q_hit[i]) hit_idx = 2'(i);
      if (!q_valid[i]) free_idx = 2'(i);
    end
  end

  // Reads are always answered with retry until the hub has completed them
  always_comb begin
    next_q_valid = q_valid;
    next_q_done = q_done;
    next_q_abort = q_abort;
    next_q_addr = q_addr;
    next_q_cmd = q_cmd;
    next_resp = pci_bridge_txn_pkg::RESP_NONE;
    next_issue = 1'b0;
    next_pf = 1'b0;
    next_len = 11'h001;
    if (hub_rd_done_i && q_valid[hub_rd_tag_i]) begin
      next_q_done[hub_rd_tag_i] = 1'b1;
      next_q_abort[hub_rd_tag_i] = hub_rd_abort_i;
    end
    if (pci_req_i && mem_rd) begin
      if (lock_active || peer_locked_i) begin
        next_resp = pci_bridge_txn_pkg::RESP_RETRY;
      end else if (|q_hit) begin
        if (q_done[hit_idx]) begin
          next_q_valid[hit_idx] = 1'b0;
          next_resp = q_abort[hit_idx] ? pci_bridge_txn_pkg::RESP_TABORT
                                       : pci_bridge_txn_pkg::RESP_DISC;
        end else begin
          next_resp = pci_bridge_txn_pkg::RESP_RETRY;
        end
      end else if (dtq_full) begin
        next_resp = pci_bridge_txn_pkg::RESP_RETRY;
      end else begin
        next_q_valid[free_idx] = 1'b1;
        next_q_done[free_idx] = 1'b0;
        next_q_abort[free_idx] = 1'b0;
        next_q_addr[free_idx] = pci_addr_i;
        next_q_cmd[free_idx] = pci_cmd_i;
        next_issue = 1'b1;
        next_resp = pci_bridge_txn_pkg::RESP_RETRY;
        if (pci_cmd_i == pci_bridge_txn_pkg::CMD_MEM_RDM && !pf_dis) begin
          next_pf = 1'b1;
          next_len = `PAGE_DWORDS - {1'b0, pci_addr_i[11:2]};
        end
      end
    end else if (pci_req_i && mem_wr) begin
      if ((lock_active && !pci_in_window_i) || peer_locked_i) begin
        next_resp = pci_bridge_txn_pkg::RESP_RETRY;
      end else if (post_full_i || pci_addr_i[1:0] != 2'b00) begin
        next_resp = pci_bridge_txn_pkg::RESP_DISC;
      end else begin
        next_resp = pci_bridge_txn_pkg::RESP_CLAIM;
      end
    end
    // I/O, configuration and own-space accesses from PCI are never claimed
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      q_valid <= '0;
      q_done <= '0;
      q_abort <= '0;
      q_addr <= '{default: 32'h0000_0000};
      q_cmd <= '{default: 4'h0};
      tgt_resp_o <= 3'h0;
      dtq_issue_o <= 1'b0;
      dtq_tag_o <= 2'h0;
      dtq_addr_o <= 32'h0000_0000;
      dtq_cmd_o <= 4'h0;
      dtq_par_o <= 1'b0;
      dtq_prefetch_o <= 1'b0;
      dtq_len_o <= 11'h000;
    end else begin
      q_valid <= next_q_valid;
      q_done <= next_q_done;
      q_abort <= next_q_abort;
      q_addr <= next_q_addr;
      q_cmd <= next_q_cmd;
      tgt_resp_o <= next_resp;
      dtq_issue_o <= next_issue;
      if (next_issue) begin
        dtq_tag_o <= free_idx;
        dtq_addr_o <= pci_addr_i;
        dtq_cmd_o <= pci_cmd_i;
        dtq_par_o <= pci_par_i;
        dtq_prefetch_o <= next_pf;
        dtq_len_o <= next_len;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  chk_claim_window: assert property (
    mst == pci_bridge_txn_pkg::M_WAIT && wait_cnt == `CLAIM_WAIT_CYC && target_claim_n_i
    && !m_special |=> hub_cpl_o && hub_cpl_status_o == pci_bridge_txn_pkg::CPL_MABORT && rma)
    else $error("missing master abort after claim window");
  chk_special_norm: assert property (
    mst == pci_bridge_txn_pkg::M_WAIT && m_special && wait_cnt == `CLAIM_WAIT_CYC
    |=> hub_cpl_o && hub_cpl_status_o == pci_bridge_txn_pkg::CPL_NORMAL && $stable(rma))
    else $error("special cycle completion wrong");
  chk_lock_drive: assert property (
    lock_active && !cycle_frame_n_o |-> !sec_bus_lock_n_o)
    else $error("lock not driven while locked");
  chk_unlock_clear: assert property (
    hub_unlock_i |=> !lock_active) else $error("unlock did not clear lock");
  chk_locked_retry: assert property (
    pci_req_i && mem_rd && lock_active |=> tgt_resp_o == pci_bridge_txn_pkg::RESP_RETRY)
    else $error("locked read not retried");
  chk_io_ignored: assert property (
    pci_req_i && !mem_rd && !mem_wr |=> tgt_resp_o == pci_bridge_txn_pkg::RESP_NONE)
    else $error("non-memory PCI cycle answered");
  chk_page_limit: assert property (
    dtq_issue_o |-> ({1'b0, dtq_addr_o[11:2]} + dtq_len_o) <= `PAGE_DWORDS)
    else $error("prefetch crosses page");
  chk_nonlinear: assert property (
    pci_req_i && mem_wr && !lock_active && !peer_locked_i && pci_addr_i[1:0] != 2'b00
    |=> tgt_resp_o == pci_bridge_txn_pkg::RESP_DISC) else $error("non-linear write kept");
  chk_frame_claim: assert property (
    $fell(cycle_frame_n_o) |-> ##[1:6] (mst == pci_bridge_txn_pkg::M_DATA || hub_cpl_o))
    else $error("claim wait overran");
  cov_master_abort: cover property (hub_cpl_o && hub_cpl_status_o == 2'h1);
  cov_lock_set: cover property ($rose(lock_active));
  cov_read_deliver: cover property (tgt_resp_o == pci_bridge_txn_pkg::RESP_DISC);
  cov_prefetch: cover property (dtq_issue_o && dtq_prefetch_o);

endmodule : pci_bridge_txn_control

// File: rtl/pci_bridge_txn_control_defs.svh
/*
  Constants of the hub-to-PCI bridge transaction controller: register map,
  field positions, reset values and cycle counts.
  Assumes inclusion by bare name from design files; definitions only.
*/
`ifndef PCI_BRIDGE_TXN_CONTROL_DEFS_SVH
`define PCI_BRIDGE_TXN_CONTROL_DEFS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define CTRL_SEC_LSB 0
`define CTRL_SUB_LSB 8
`define CTRL_PFDIS_BIT 16
`define STATUS_RMA_BIT 0
`define STATUS_LOCK_BIT 1
`define STATUS_FULL_BIT 2
`define CTRL_RESET 32'h0000_0000

// ----------------------------------------------------------------------
// Decode and timing
// ----------------------------------------------------------------------
`define OWN_DEV_MIN 5'h1B
`define SPC_DEV 5'h1F
`define SPC_FUNC 3'h7
`define SPC_REG 6'h3F
`define CLAIM_WAIT_CYC 3'h5
`define LAT_TIMER_CYC 8'h40
`define PAGE_DWORDS 11'h400
`define DTQ_DEPTH 4

`endif

// File: rtl/pci_bridge_txn_pkg.sv
/*
  Types of the hub-to-PCI bridge transaction controller.
  Assumes no surroundings; the constants live in the _defs header.
*/
package pci_bridge_txn_pkg;
  typedef enum logic [2:0] {M_IDLE, M_ARB, M_ADDR, M_WAIT, M_DATA} master_state_e;
  typedef enum logic [2:0] {RESP_NONE, RESP_CLAIM, RESP_RETRY, RESP_DISC, RESP_TABORT} tgt_resp_e;
  typedef enum logic [1:0] {CPL_NORMAL, CPL_MABORT, CPL_TABORT} cpl_status_e;
  typedef logic [3:0] cmd_t;
  localparam cmd_t CMD_SPECIAL = 4'h1;
  localparam cmd_t CMD_MEM_RD = 4'h6;
  localparam cmd_t CMD_MEM_WR = 4'h7;
  localparam cmd_t CMD_CFG_RD = 4'hA;
  localparam cmd_t CMD_CFG_WR = 4'hB;
  localparam cmd_t CMD_MEM_RDM = 4'hC;
  localparam cmd_t CMD_MEM_RDL = 4'hE;
  localparam cmd_t CMD_MEM_WRI = 4'hF;
endpackage : pci_bridge_txn_pkg

// File: tb/pci_target_model.sv
/*
  Target model on the secondary bus: parks the grant, claims after a chosen
  delay and is ready with the claim; delay 7 never claims. Read data is the
  inverted address of the frame, so the bench can predict it.
  Assumes frame, address and delay are synchronous to ref_clk_i.
*/
module pci_target_model (
  input wire logic ref_clk_i,
  input wire logic frame_n_i,
  input wire logic [31:0] addr_i,
  input wire logic [2:0] delay_i,
  output logic gnt_n_o,
  output logic claim_n_o = 1'b1,
  output logic ready_n_o = 1'b1,
  output logic stop_n_o,
  output logic [31:0] rdata_o,
  output logic [31:0] seen_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cnt = 3'h0;
  assign gnt_n_o = 1'b0;
  assign stop_n_o = 1'b1;
  // Claim within the wait, ready with it; data is latched at the address phase
  always @(posedge ref_clk_i) begin
    cnt <= frame_n_i ? 3'h0 : cnt + 3'h1;
    claim_n_o <= frame_n_i || cnt + 3'h1 < delay_i || delay_i == 3'h7;
    ready_n_o <= frame_n_i || cnt + 3'h1 < delay_i || delay_i == 3'h7;
    if (!frame_n_i && cnt == 3'h0) begin
      seen_o <= addr_i;
      rdata_o <= ~addr_i;
    end
  end
endmodule : pci_target_model

// File: tb/tb_top.sv
/*
  Self-checking bench: register port, hub cycles against the target model,
  and PCI-side target answers with the delayed-read queue.
  Assumes the design package and header are compiled first.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_i = 0, rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, hub_req_i = 0;
  logic pci_req_i = 0, pci_par_i = 0, hub_rd_done_i = 0, hub_rd_abort_i = 0;
  logic hub_locked_i = 0, hub_unlock_i = 0, post_full_i = 0, peer_locked_i = 0;
  logic pci_in_window_i = 1, hub_ready_o, hub_cpl_o, hub_cpl_disc_o, own_cfg_o;
  logic sec_addr_data_oe_o, cycle_frame_n_o, sec_bus_lock_n_o, upstream_block_o;
  logic dtq_issue_o, dtq_par_o, dtq_prefetch_o, sec_gnt_n_i, target_claim_n_i;
  logic target_ready_n_i, target_stop_n_i;
  logic [1:0] hub_rd_tag_i = 0, hub_cpl_status_o, dtq_tag_o;
  logic [2:0] dly = 1, tgt_resp_o;
  logic [3:0] hub_cmd_i = 0, hub_be_i = 0, pci_cmd_i = 0, sec_cmd_o, dtq_cmd_o;
  logic [7:0] reg_addr_i = 0, hub_len_i = 1;
  logic [10:0] dtq_len_o;
  logic [31:0] reg_wdata_i = 0, hub_addr_i = 0, hub_wdata_i = 0, pci_addr_i = 0, d, a;
  logic [31:0] reg_rdata_o, hub_rdata_o, sec_addr_data_i, sec_addr_data_o, dtq_addr_o, seen;
  int n_fail = 0, checks = 0, cyc = 0;

  pci_bridge_txn_control u_dut (.*);
  pci_target_model u_tgt (.ref_clk_i(ref_clk_i), .frame_n_i(cycle_frame_n_o),
    .addr_i(sec_addr_data_o), .delay_i(dly), .gnt_n_o(sec_gnt_n_i),
    .claim_n_o(target_claim_n_i), .ready_n_o(target_ready_n_i),
    .stop_n_o(target_stop_n_i), .rdata_o(sec_addr_data_i), .seen_o(seen));

  initial forever #4 ref_clk_i = ~ref_clk_i;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Expected one-hot device select of a converted Type 0 address
  function automatic logic [15:0] exp_sel(input logic [4:0] dev);
    return dev < 5'h10 ? 16'h0001 << dev : 16'h0000;
  endfunction : exp_sel

  task automatic finish_test;
    if (n_fail == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test

  // Hang guard: the whole run needs well under this many cycles
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc > 5000) begin
      n_fail++;
      finish_test();
    end
  end

  // Register access; read data lands in d
  task automatic acc(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge ref_clk_i);
    reg_addr_i <= ad;
    reg_wdata_i <= wd;
    reg_wr_i <= w;
    reg_rd_i <= !w;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask : acc

  task automatic hub(input logic [3:0] c, input logic [31:0] ad, input logic [2:0] dl,
                     input logic [7:0] len, input logic [1:0] st);
    @(posedge ref_clk_i);
    dly <= dl;
    hub_cmd_i <= c;
    hub_addr_i <= ad;
    hub_len_i <= len;
    hub_be_i <= 4'($urandom_range(15, 1));
    hub_wdata_i <= $urandom;
    hub_req_i <= 1'b1;
    @(posedge ref_clk_i);
    hub_req_i <= 1'b0;
    #1;
    for (int n = 0; n < 40 && hub_cpl_o !== 1'b1; n++) begin
      @(posedge ref_clk_i);
      #1;
    end
    chk(hub_cpl_status_o, st);
    chk(hub_ready_o, 1);
  endtask : hub

  task automatic pci(input logic [3:0] c, input logic [31:0] ad, input logic [2:0] r);
    @(posedge ref_clk_i);
    pci_cmd_i <= c;
    pci_addr_i <= ad;
    pci_par_i <= 1'($urandom);
    pci_req_i <= 1'b1;
    @(posedge ref_clk_i);
    pci_req_i <= 1'b0;
    #1 chk(tgt_resp_o, r);
  endtask : pci

  task automatic done(input logic [1:0] t, input logic ab);
    @(posedge ref_clk_i);
    hub_rd_tag_i <= t;
    hub_rd_abort_i <= ab;
    hub_rd_done_i <= 1'b1;
    @(posedge ref_clk_i);
    hub_rd_done_i <= 1'b0;
  endtask : done

  // Main sequence: corners first, random addresses and delays among them
  initial begin
    void'($urandom(12393));
    repeat (6) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    acc(0, 8'h00, 0);
    chk(d, 0);
    acc(0, 8'h40, 0);
    chk(d, 0);
    acc(1, 8'h00, 32'h0000_0301);
    hub(pci_bridge_txn_pkg::CMD_MEM_WR, 32'h0000_1000, 3'($urandom_range(5, 1)), 1, 0);
    for (int i = 26; i < 32; i++) begin
      hub(pci_bridge_txn_pkg::CMD_CFG_RD, {16'h0, 5'(i), 11'h0}, 7, 1, {1'b0, i < 27});
      chk(own_cfg_o, i > 26);
    end
    for (int k = 0; k < 4; k++) begin
      a = {16'h0001, 5'(k == 0 ? 16 : $urandom_range(31)), 11'h001};
      hub(pci_bridge_txn_pkg::CMD_CFG_WR, a, 3'($urandom_range(5, 1)), 1, 0);
      chk(seen[31:16], exp_sel(a[15:11]));
    end
    a = 32'h0002_0801;
    hub(pci_bridge_txn_pkg::CMD_CFG_RD, a, 7, 1, 1);
    chk(seen, a);
    acc(0, 8'h04, 0);
    chk(d, 1);
    acc(1, 8'h04, 1);
    a = 32'h0001_FFFD;
    hub(pci_bridge_txn_pkg::CMD_CFG_WR, a, 7, 2, 0);
    chk(hub_cpl_disc_o, 1);
    chk(sec_cmd_o, 4'h1);
    chk(seen, a);
    acc(0, 8'h04, 0);
    chk(d, 0);
    for (int k = 0; k < 4; k++) begin
      if (k == 2) acc(1, 8'h00, 32'h0001_0301);
      a = $urandom & (k == 0 ? 32'hFFFF_FFFC : 32'hFFFF_F000);
      pci(pci_bridge_txn_pkg::CMD_MEM_RDM, a, 2);
      chk(dtq_issue_o, 1);
      chk(dtq_addr_o, a);
      chk({dtq_cmd_o, dtq_par_o}, {4'hC, pci_par_i});
      chk(dtq_prefetch_o, k < 2);
      if (k < 2) chk(dtq_len_o, 11'h400 - a[11:2]);
      pci(pci_bridge_txn_pkg::CMD_MEM_RDM, a, 2);
      done(dtq_tag_o, k[0]);
      pci(pci_bridge_txn_pkg::CMD_MEM_RDM, a, k[0] ? 4 : 3);
    end
    // Lock: set by a claimed locked read, blocks PCI reads, cleared by unlock
    hub_locked_i <= 1'b1;
    hub(pci_bridge_txn_pkg::CMD_MEM_RD, a, 3'($urandom_range(5, 1)), 1, 0);
    hub_locked_i <= 1'b0;
    chk(hub_rdata_o, ~a);
    chk(upstream_block_o, 1);
    hub(pci_bridge_txn_pkg::CMD_MEM_WR, a, 1, 1, 0);
    acc(0, 8'h04, 0);
    chk(d, 2);
    pci(pci_bridge_txn_pkg::CMD_MEM_RD, a, 2);
    chk(dtq_issue_o, 0);
    pci(pci_bridge_txn_pkg::CMD_MEM_WR, a & 32'hFFFF_FFFC, 1);
    pci_in_window_i <= 1'b0;
    pci(pci_bridge_txn_pkg::CMD_MEM_WR, a & 32'hFFFF_FFFC, 2);
    pci_in_window_i <= 1'b1;
    @(posedge ref_clk_i) hub_unlock_i <= 1'b1;
    @(posedge ref_clk_i) hub_unlock_i <= 1'b0;
    #1 chk(upstream_block_o, 0);
    peer_locked_i <= 1'b1;
    pci(pci_bridge_txn_pkg::CMD_MEM_RD, a, 2);
    chk(dtq_issue_o, 0);
    peer_locked_i <= 1'b0;
    pci(pci_bridge_txn_pkg::CMD_MEM_WR, a | 32'h0000_0001, 3);
    // Fill the delayed-read queue, then a fifth read is retried unqueued
    for (int j = 0; j < 4; j++) pci(pci_bridge_txn_pkg::CMD_MEM_RD, 32'(j) << 8, 2);
    acc(0, 8'h04, 0);
    chk(d, 4);
    pci(pci_bridge_txn_pkg::CMD_MEM_RD, 32'h0000_0800, 2);
    chk(dtq_issue_o, 0);
    pci(4'h2, a, 0);
    pci(pci_bridge_txn_pkg::CMD_CFG_RD, a, 0);
    finish_test();
  end
endmodule : tb_top
